/* File: shared/smr_pkg.sv */
// Package for the sync monitor register bank: offsets, fields, reset values, timing.
// Assumes a single 50 MHz clock domain.
package smr_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam logic [7:0] OFF_SRC_SEL     = 8'h20;
  localparam logic [7:0] OFF_RSV_A       = 8'h21;
  localparam logic [7:0] OFF_RSV_B       = 8'h22;
  localparam logic [7:0] OFF_WIN_WIDTH   = 8'h23;
  localparam logic [7:0] OFF_ACT_STAT    = 8'h24;
  localparam logic [7:0] OFF_POL_STAT    = 8'h25;
  localparam logic [7:0] OFF_CNT_HIGH    = 8'h26;
  localparam logic [7:0] OFF_CNT_LOW     = 8'h27;
  localparam logic [7:0] OFF_FIX_ONE     = 8'h28;
  localparam logic [7:0] OFF_FIX_TWO     = 8'h29;
  localparam logic [7:0] OFF_FUT_ONE     = 8'h2a;
  localparam logic [7:0] OFF_FUT_TWO     = 8'h2b;
  localparam logic [7:0] OFF_HOLD_CTL    = 8'h2c;
  localparam logic [7:0] OFF_FIX_FIVE    = 8'h2d;
  localparam logic [7:0] OFF_FIX_SIX     = 8'h2e;
  localparam logic [7:0] OFF_CPF         = 8'h34;
  // Field positions
  localparam int unsigned BIT_PLL_FILT   = 2;
  localparam int unsigned BIT_PROC_REGEN = 1;
  localparam int unsigned BIT_OFF_HOLD   = 4;
  localparam int unsigned BIT_CPF_EN     = 2;
  // Reset values
  localparam logic [7:0] RST_SRC_SEL     = 8'h08;
  localparam logic [7:0] RST_RSV         = 8'h00;
  localparam logic [7:0] RST_WIN_WIDTH   = 8'h0a;
  localparam logic [7:0] RST_FIX         = 8'h00;
  localparam logic [7:0] RST_FUT         = 8'h00;
  localparam logic [7:0] RST_HOLD_CTL    = 8'h00;
  localparam logic [7:0] RST_CPF         = 8'h00;
  // Timing
  localparam int unsigned WIN_STEP_NS    = 25;
  localparam int unsigned CPF_MIN_NS     = 250;
  localparam int unsigned CPF_MIN_CYC    = (CPF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACT_TIMEOUT    = 65535;
  localparam int unsigned OFF_SETTLE_UPD = 10;
endpackage

/* File: src/smr_sync_monitor.sv */
// Sync monitor register bank: sync source selection, sync filter, status and counters.
// Assumes sync inputs synchronous to clk; simple strobe register port, read data one cycle later.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
module smr_sync_monitor
  import smr_pkg::*;
#(
  parameter int unsigned ACT_CYCLES = ACT_TIMEOUT,
  parameter int unsigned OFF_PERIOD = 192
)(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       line_sync_in_0,
  input  wire logic       line_sync_in_1,
  input  wire logic       frame_sync_in_0,
  input  wire logic       frame_sync_in_1,
  input  wire logic       composite_sync_in_0,
  input  wire logic       composite_sync_in_1,
  input  wire logic       ext_clock_or_holdover_pin,
  input  wire logic       ext_clamp_in,
  input  wire logic       input_sel,
  input  wire logic       use_composite,
  output logic            pll_sync,
  output logic            proc_sync,
  output logic            offset_update_en,
  output logic            offset_settled
);
  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] src_sel, rsv_a, rsv_b, win_width, fix_one, fix_two;
  logic [7:0] hold_ctl, fix_five, fix_six, cpf;
  logic [7:0] act_stat, pol_stat;
  logic [11:0] line_count;
  logic       ext_flag, lock_flag;

  // Write decode; read-only offsets fall through
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      src_sel   <= RST_SRC_SEL;
      rsv_a     <= RST_RSV;
      rsv_b     <= RST_RSV;
      win_width <= RST_WIN_WIDTH;
      fix_one   <= RST_FIX;
      fix_two   <= RST_FIX;
      hold_ctl  <= RST_HOLD_CTL;
      fix_five  <= RST_FIX;
      fix_six   <= RST_FIX;
      cpf       <= RST_CPF;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        OFF_SRC_SEL:   src_sel   <= reg_wdata;
        OFF_RSV_A:     rsv_a     <= reg_wdata;
        OFF_RSV_B:     rsv_b     <= reg_wdata;
        OFF_WIN_WIDTH: win_width <= reg_wdata;
        OFF_FIX_ONE:   fix_one   <= reg_wdata;
        OFF_FIX_TWO:   fix_two   <= reg_wdata;
        OFF_HOLD_CTL:  hold_ctl  <= reg_wdata;
        OFF_FIX_FIVE:  fix_five  <= reg_wdata;
        OFF_FIX_SIX:   fix_six   <= reg_wdata;
        OFF_CPF:       cpf       <= reg_wdata;
        default:       ;
      endcase
    end
  end

  // Read mux, data in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        OFF_SRC_SEL:   reg_rdata <= src_sel;
        OFF_RSV_A:     reg_rdata <= rsv_a;
        OFF_RSV_B:     reg_rdata <= rsv_b;
        OFF_WIN_WIDTH: reg_rdata <= win_width;
        OFF_ACT_STAT:  reg_rdata <= act_stat;
        OFF_POL_STAT:  reg_rdata <= pol_stat;
        OFF_CNT_HIGH:  reg_rdata <= line_count[11:4];
        OFF_CNT_LOW:   reg_rdata <= {line_count[3:0], 4'h0};
        OFF_FIX_ONE:   reg_rdata <= fix_one;
        OFF_FIX_TWO:   reg_rdata <= fix_two;
        OFF_FUT_ONE:   reg_rdata <= RST_FUT;
        OFF_FUT_TWO:   reg_rdata <= RST_FUT;
        OFF_HOLD_CTL:  reg_rdata <= hold_ctl;
        OFF_FIX_FIVE:  reg_rdata <= fix_five;
        OFF_FIX_SIX:   reg_rdata <= fix_six;
        OFF_CPF:       reg_rdata <= cpf;
        default:       reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ****************************************************************
  // Input history and activity / polarity detection
  // ****************************************************************
  localparam int NIN = 8;
  logic [NIN-1:0] pins, pins_q;
  logic [15:0]    idle_cnt [NIN];
  logic [15:0]    high_cnt [NIN];
  logic [NIN-1:0] act, pol;
  assign pins = {line_sync_in_0, line_sync_in_1, frame_sync_in_0, frame_sync_in_1,
                 composite_sync_in_0, composite_sync_in_1, ext_clock_or_holdover_pin, ext_clamp_in};

  // Per-input edge timeout and duty tracking over one idle window
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pins_q <= '0;
      act    <= '0;
      pol    <= '0;
      for (int i = 0; i < NIN; i++)
      begin
        idle_cnt[i] <= '0;
        high_cnt[i] <= '0;
      end
    end
    else
    begin
      pins_q <= pins;
      for (int i = 0; i < NIN; i++)
      begin
        if (pins[i] != pins_q[i])
        begin
          idle_cnt[i] <= '0;
          act[i]      <= 1'b1;
        end
        else if (idle_cnt[i] >= 16'(ACT_CYCLES))
          act[i] <= 1'b0;
        else
          idle_cnt[i] <= idle_cnt[i] + 16'h0001;
        // Polarity: level held longer is the inactive one
        if (pins[i] != pins_q[i] && pins[i])
        begin
          pol[i]      <= (idle_cnt[i] > high_cnt[i]);
          high_cnt[i] <= '0;
        end
        else if (pins[i] != pins_q[i] && !pins[i])
          high_cnt[i] <= idle_cnt[i];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      act_stat <= 8'h00;
      pol_stat <= 8'h00;
    end
    else
    begin
      act_stat <= act;
      pol_stat <= {pol[7], pol[6], pol[5], pol[4], pol[1], pol[0], ext_flag, lock_flag};
    end
  end

  // ****************************************************************
  // Composite pulse filter and source selection
  // ****************************************************************
  logic       comp_raw, comp_q, comp_filt;
  logic [7:0] comp_run;
  logic       line_raw, regen;
  assign comp_raw = input_sel ? composite_sync_in_1 : composite_sync_in_0;

  // Level passes only after standing CPF_MIN_CYC cycles when enabled
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      comp_q    <= 1'b0;
      comp_run  <= '0;
      comp_filt <= 1'b0;
    end
    else
    begin
      comp_q <= comp_raw;
      if (comp_raw != comp_q)
        comp_run <= '0;
      else if (comp_run != 8'hff)
        comp_run <= comp_run + 8'h01;
      if (!cpf[BIT_CPF_EN] || comp_run >= 8'(CPF_MIN_CYC - 1))
        comp_filt <= comp_q;
    end
  end

  assign line_raw = use_composite ? comp_filt : (input_sel ? line_sync_in_1 : line_sync_in_0);

  // ****************************************************************
  // Line sync filter: window around expected leading edge
  // ****************************************************************
  logic [15:0] per_cnt, per_len;
  logic [15:0] win_cyc;
  logic        raw_q, lead, in_win;
  logic [2:0]  good_run;
  assign lead    = line_raw & ~raw_q;
  assign win_cyc = 16'((int'(win_width) * WIN_STEP_NS) / CLK_PERIOD_NS);
  assign in_win  = (per_cnt + win_cyc >= per_len) || (per_cnt <= win_cyc);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      raw_q     <= 1'b0;
      per_cnt   <= '0;
      per_len   <= '0;
      regen     <= 1'b0;
      good_run  <= '0;
      lock_flag <= 1'b0;
      ext_flag  <= 1'b0;
    end
    else
    begin
      raw_q   <= line_raw;
      per_cnt <= (per_cnt == 16'hffff) ? per_cnt : per_cnt + 16'h0001;
      regen   <= 1'b0;
      if (lead && (in_win || !lock_flag))
      begin
        per_len  <= per_cnt;
        per_cnt  <= '0;
        regen    <= 1'b1;
        good_run <= (good_run == 3'h7) ? good_run : good_run + 3'h1;
        lock_flag <= (good_run >= 3'h3);
        ext_flag  <= 1'b0;
      end
      else if (lead)
      begin
        ext_flag <= 1'b1;
        good_run <= '0;
      end
      else if (per_cnt > per_len + win_cyc && lock_flag)
      begin
        lock_flag <= 1'b0;
        good_run  <= '0;
      end
    end
  end

  // PLL and sync-processor source multiplexers
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pll_sync  <= 1'b0;
      proc_sync <= 1'b0;
    end
    else
    begin
      pll_sync  <= src_sel[BIT_PLL_FILT] ? regen : line_raw;
      proc_sync <= src_sel[BIT_PROC_REGEN] ? regen : lead;
    end
  end

  // ****************************************************************
  // Line per frame counter on the processor source
  // ****************************************************************
  logic [11:0] run_count;
  logic        frame_q, frame_lead, proc_edge;
  assign frame_lead = (input_sel ? frame_sync_in_1 : frame_sync_in_0) & ~frame_q;
  assign proc_edge  = src_sel[BIT_PROC_REGEN] ? regen : lead;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      frame_q    <= 1'b0;
      run_count  <= '0;
      line_count <= '0;
    end
    else
    begin
      frame_q <= input_sel ? frame_sync_in_1 : frame_sync_in_0;
      if (frame_lead)
      begin
        line_count <= run_count;
        run_count  <= 12'(proc_edge);
      end
      else if (proc_edge)
        run_count <= run_count + 12'h001;
    end
  end

  // ****************************************************************
  // Auto-offset update pacing and hold
  // ****************************************************************
  logic [15:0] upd_lines;
  logic [3:0]  upd_done;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      upd_lines        <= '0;
      upd_done         <= '0;
      offset_update_en <= 1'b0;
      offset_settled   <= 1'b0;
    end
    else
    begin
      offset_update_en <= 1'b0;
      if (hold_ctl[BIT_OFF_HOLD])
        upd_done <= '0;
      else if (proc_edge)
      begin
        if (upd_lines >= 16'(OFF_PERIOD - 1))
        begin
          upd_lines        <= '0;
          offset_update_en <= 1'b1;
          if (upd_done != 4'(OFF_SETTLE_UPD))
            upd_done <= upd_done + 4'h1;
        end
        else
          upd_lines <= upd_lines + 16'h0001;
      end
      offset_settled <= (upd_done == 4'(OFF_SETTLE_UPD));
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_pll_select: assert property (@(posedge clk) disable iff (sys_rst)
    !src_sel[BIT_PLL_FILT] && $stable(src_sel) |=> pll_sync == $past(line_raw))
    else $error("pll raw path wrong");
  a_proc_select: assert property (@(posedge clk) disable iff (sys_rst)
    src_sel[BIT_PROC_REGEN] && $stable(src_sel) |=> proc_sync == $past(regen))
    else $error("proc regen path wrong");
  a_count_read: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && reg_addr == OFF_CNT_LOW |=> reg_rdata[3:0] == 4'h0)
    else $error("count low nibble not zero");
  a_future_ro: assert property (@(posedge clk) disable iff (sys_rst)
    reg_rd && (reg_addr == OFF_FUT_ONE || reg_addr == OFF_FUT_TWO) |=> reg_rdata == RST_FUT)
    else $error("future register changed");
  a_hold_freeze: assert property (@(posedge clk) disable iff (sys_rst)
    hold_ctl[BIT_OFF_HOLD] |=> !offset_update_en) else $error("update while held");
  a_act_edge: assert property (@(posedge clk) disable iff (sys_rst)
    pins[7] != pins_q[7] |=> ##1 act_stat[7]) else $error("activity missed");
  a_clamp_act: assert property (@(posedge clk) disable iff (sys_rst)
    pins[0] != pins_q[0] |=> ##1 act_stat[0]) else $error("clamp activity missed");
  a_win_reset: assert property (@(posedge clk) $fell(sys_rst) |-> win_width == RST_WIN_WIDTH && !src_sel[BIT_PLL_FILT])
    else $error("reset values wrong");
  a_cpf_block: assert property (@(posedge clk) disable iff (sys_rst)
    cpf[BIT_CPF_EN] && comp_run < 8'(CPF_MIN_CYC - 1) |=> comp_filt == $past(comp_filt))
    else $error("short pulse passed");
endmodule

/* File: verification/smr_sync_source.sv */
// Video source model: positive line, frame and composite sync pulses.
// Assumes the bench clock; outputs move just after rising edges.
`timescale 1ns/10ps
module smr_sync_source #(
  parameter int LINE_CYC = 64,
  parameter int PW       = 16,
  parameter int LINES    = 21
)(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic run,
  input  wire logic short_pulse,
  output logic      line_out,
  output logic      frame_out,
  output logic      comp_out
);
  int pos;
  int line_no;
  // Position in line and line number in frame
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pos     <= 0;
      line_no <= 0;
    end
    else if (run)
    begin
      pos <= (pos == LINE_CYC - 1) ? 0 : pos + 1;
      if (pos == LINE_CYC - 1)
        line_no <= (line_no == LINES - 1) ? 0 : line_no + 1;
    end
  end
  // Frame edge mid-line so the line count has no tie; static low when stopped
  assign line_out  = run && pos < PW;
  assign comp_out  = run && pos < (short_pulse ? 5 : PW);
  assign frame_out = run && ((line_no == 0 && pos >= 32) || (line_no == 1 && pos < 32));
endmodule

/* File: verification/tb.sv */
// Bench for the sync monitor register bank.
// Assumes smr_pkg and the sync source model are compiled first.
`timescale 1ns/10ps
module tb;
  import smr_pkg::*;
  localparam int ACT = 2048;
  localparam int LN  = 64;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic       run = 1'b0;
  logic       short_pulse = 1'b0;
  logic       use_composite = 1'b0;
  logic       s_line, s_frame, s_comp;
  logic       pll_sync, proc_sync, offset_update_en, offset_settled;
  logic [7:0] d, e;
  int         pll_hi, proc_hi, upd, cycles, mismatches, n_tests;
  // ****************************************
  // Clock, counters and instances
  // ****************************************
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      stop_test;
    end
  end
  smr_sync_source #(.LINE_CYC(LN)) u_src (.clk(clk), .sys_rst(sys_rst), .run(run),
    .short_pulse(short_pulse), .line_out(s_line), .frame_out(s_frame), .comp_out(s_comp));
  smr_sync_monitor #(.ACT_CYCLES(ACT), .OFF_PERIOD(4)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .line_sync_in_0(s_line), .line_sync_in_1(1'b1),
    .frame_sync_in_0(s_frame), .frame_sync_in_1(1'b0), .composite_sync_in_0(s_comp),
    .composite_sync_in_1(1'b0), .ext_clock_or_holdover_pin(s_line), .ext_clamp_in(s_line),
    .input_sel(1'b0), .use_composite(use_composite), .pll_sync(pll_sync),
    .proc_sync(proc_sync), .offset_update_en(offset_update_en),
    .offset_settled(offset_settled));
  // Compare and report
  task automatic chk(input string name, input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), {4'h0, v & m}, {4'h0, exp});
  endtask
  // Count pll, processor and update high cycles over n cycles, one edge of slack first
  task automatic count(input int n);
    @(posedge clk);
    pll_hi  = 0;
    proc_hi = 0;
    upd     = 0;
    repeat (n)
    begin
      @(posedge clk);
      pll_hi  += pll_sync;
      proc_hi += proc_sync;
      upd     += offset_update_en;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] offs [12] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h28, 8'h29, 8'h2a, 8'h2b,
                              8'h2c, 8'h2d, 8'h2e, 8'h34};
    foreach (offs[i])
      rc(offs[i], offs[i] == 8'h20 ? 8'h08 : offs[i] == 8'h23 ? 8'h0a : 8'h00);
  endtask
  task automatic t_rw;
    logic [7:0] offs [8] = '{8'h20, 8'h28, 8'h29, 8'h2d, 8'h2e, 8'h23, 8'h2a, 8'h2b};
    logic [7:0] vals [8] = '{8'h09, 8'hbf, 8'h02, 8'he8, 8'he0, 8'h0a, 8'hff, 8'hff};
    foreach (offs[i])
      wr(offs[i], vals[i]);
    foreach (offs[i])
      rc(offs[i], i > 5 ? 8'h00 : vals[i]);
    wr(8'h30, 8'h5a);
    rc(8'h30, 8'h00);
  endtask
  task automatic t_status;
    run <= 1'b1;
    repeat (3 * 21 * LN) @(posedge clk);
    rc(OFF_ACT_STAT, 8'hab);
    rc(OFF_POL_STAT, 8'had, 8'haf);
    rd(OFF_CNT_HIGH, d);
    rd(OFF_CNT_LOW, e);
    chk("line count", {d, e[7:4]}, 12'd21);
    run <= 1'b0;
    repeat (ACT + 8) @(posedge clk);
    rc(OFF_ACT_STAT, 8'h00);
    run <= 1'b1;
    repeat (8 * LN) @(posedge clk);
  endtask
  task automatic t_pll;
    count(4 * LN);
    chk("pll raw", 12'(pll_hi), 12'd64);
    chk("proc raw", 12'(proc_hi), 12'd4);
    use_composite <= 1'b1;
    short_pulse   <= 1'b1;
    repeat (2 * LN) @(posedge clk);
    count(4 * LN);
    chk("short pass", 12'(pll_hi), 12'd20);
    wr(OFF_CPF, 8'h04);
    repeat (2 * LN) @(posedge clk);
    count(4 * LN);
    chk("short block", 12'(pll_hi), 12'd0);
    short_pulse <= 1'b0;
    repeat (2 * LN) @(posedge clk);
    count(4 * LN);
    chk("long pass", 12'(pll_hi), 12'd64);
    wr(OFF_CPF, 8'h00);
    use_composite <= 1'b0;
    wr(OFF_SRC_SEL, 8'h0f);
    repeat (8 * LN) @(posedge clk);
    count(4 * LN);
    chk("pll filtered", 12'(pll_hi), 12'd4);
    chk("proc regen", 12'(proc_hi), 12'd4);
  endtask
  task automatic t_hold;
    count(32 * LN);
    chk("updates", 12'(upd), 12'd8);
    chk("settled", {11'h0, offset_settled}, 12'd1);
    wr(OFF_HOLD_CTL, 8'h10);
    count(32 * LN);
    chk("held", 12'(upd), 12'd0);
    wr(OFF_HOLD_CTL, 8'h00);
    count(8 * 4 * LN);
    chk("not settled", {11'h0, offset_settled}, 12'd0);
    count(7 * 4 * LN);
    chk("updates again", 12'(upd), 12'd7);
    chk("settled again", {11'h0, offset_settled}, 12'd1);
    wr(OFF_HOLD_CTL, 8'h10);
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_rw;
    t_status;
    t_pll;
    t_hold;
    stop_test;
  end
endmodule
